//--- logic/rvs_regs.sv
// Purpose: Voltage code registers for converter six and linear regulators two and three
// Assumes: Register port is the decoded byte access of the management bus engine
// Notes:   Rail codes switch with the sleep level; outputs are registered
`timescale 1ns/10ps
`include "rvs_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] Hold 7-bit converter six sleep code in bits 7:1; apply it during sleep.
// [R2] Converter code is read in 10 mV or 25 mV steps per range select.
// [R3] Hold linear regulator two sleep code in bits 7:4; drive it in sleep.
// [R4] Hold linear regulator two normal code in bits 3:0; drive it outside sleep.
// [R5] Hold linear regulator three sleep code in bits 7:4; apply it in sleep.
// [R6] Hold linear regulator three normal code in bits 3:0; apply it normally.
// [R7] Converter six normal code sits in bits 7:1 at 0x98; switch on mode change.
// [R8] Factory defaults at reset; converter sleep bit 0 reads zero, ignores writes.
module rvs_regs #(
  parameter int unsigned VARIANT = 0
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  // Mode and range
  input  wire logic       sleep_in,
  input  wire logic       conv6_range_25mv_in,
  // Rail targets
  output logic      [6:0] conv6_target_code_out,
  output logic      [4:0] conv6_step_mv_out,
  output logic            conv6_decay_out,
  output logic      [3:0] linreg2_code_out,
  output logic      [3:0] linreg3_code_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Factory defaults, one byte per variant
  localparam logic [31:0] DEF_N  = `RVS_DEF_CONV6_NORMAL;
  localparam logic [31:0] DEF_S  = `RVS_DEF_CONV6_SLEEP;
  localparam logic [31:0] DEF_L2 = `RVS_DEF_LINREG2_PAIR;
  localparam logic [31:0] DEF_L3 = `RVS_DEF_LINREG3_PAIR;
  localparam int unsigned VSEL   = (VARIANT > 3) ? 0 : VARIANT;
  localparam logic [7:0]  RST_N  = DEF_N[VSEL*8 +: 8];
  localparam logic [7:0]  RST_S  = DEF_S[VSEL*8 +: 8] & `RVS_SLEEP_WMASK;
  localparam logic [7:0]  RST_L2 = DEF_L2[VSEL*8 +: 8];
  localparam logic [7:0]  RST_L3 = DEF_L3[VSEL*8 +: 8];

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  rvs_pkg::rvs_byte_t conv6_normal_q;
  rvs_pkg::rvs_byte_t conv6_sleep_q;
  rvs_pkg::rvs_byte_t linreg2_pair_q;
  rvs_pkg::rvs_byte_t linreg3_pair_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic       hit_n   = (reg_addr_in == `RVS_OFS_CONV6_NORMAL);
  wire logic       hit_s   = (reg_addr_in == `RVS_OFS_CONV6_SLEEP);
  wire logic       hit_l2  = (reg_addr_in == `RVS_OFS_LINREG2_PAIR);
  wire logic       hit_l3  = (reg_addr_in == `RVS_OFS_LINREG3_PAIR);
  wire logic       mapped  = hit_n | hit_s | hit_l2 | hit_l3;
  // Low offset bits pick the register once the full offset has hit
  rvs_pkg::rvs_sel_t sel;
  assign sel = rvs_pkg::rvs_sel_t'(reg_addr_in[1:0]);

  // Read mux; unmapped offsets answer a fixed zero byte
  wire logic [7:0] rd_mux  = !mapped ? `RVS_UNMAPPED_DATA :
                             (sel == rvs_pkg::RVS_SEL_CONV6_NORMAL) ? conv6_normal_q :
                             (sel == rvs_pkg::RVS_SEL_CONV6_SLEEP)  ? conv6_sleep_q  :
                             (sel == rvs_pkg::RVS_SEL_LINREG2_PAIR) ? linreg2_pair_q :
                                                                     linreg3_pair_q;

  // Write data; bit 0 of the sleep register is forced low
  wire logic [7:0] s_wdata = reg_wdata_in & `RVS_SLEEP_WMASK; // R8

  ////////////////////////////////////////////////////////////////////////////////
  // Target selection by mode
  wire logic [6:0] conv6_code_d = sleep_in ? conv6_sleep_q[`RVS_CODE7_MSB:`RVS_CODE7_LSB]   // R1
                                           : conv6_normal_q[`RVS_CODE7_MSB:`RVS_CODE7_LSB]; // R7
  wire logic [3:0] linreg2_d    = sleep_in ? linreg2_pair_q[`RVS_SLEEP_MSB:`RVS_SLEEP_LSB]   // R3
                                           : linreg2_pair_q[`RVS_NORMAL_MSB:`RVS_NORMAL_LSB]; // R4
  wire logic [3:0] linreg3_d    = sleep_in ? linreg3_pair_q[`RVS_SLEEP_MSB:`RVS_SLEEP_LSB]   // R5
                                           : linreg3_pair_q[`RVS_NORMAL_MSB:`RVS_NORMAL_LSB]; // R6
  // Step size only labels the code; the analog table does the rest
  wire logic [4:0] step_d       = conv6_range_25mv_in ? `RVS_STEP_COARSE_MV : `RVS_STEP_FINE_MV; // R2

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv6_normal_q <= RST_N;  // R8
      conv6_sleep_q  <= RST_S;  // R8
      linreg2_pair_q <= RST_L2; // R8
      linreg3_pair_q <= RST_L3; // R8
    end else if (reg_wr_in) begin
      if (hit_n)  conv6_normal_q <= reg_wdata_in; // R7
      if (hit_s)  conv6_sleep_q  <= s_wdata;      // R1
      if (hit_l2) linreg2_pair_q <= reg_wdata_in; // R3
      if (hit_l3) linreg3_pair_q <= reg_wdata_in; // R5
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out  <= reg_rd_in ? rd_mux : reg_rdata_out;
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // Outputs start from the reset targets of normal mode
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv6_target_code_out <= RST_N[`RVS_CODE7_MSB:`RVS_CODE7_LSB];
      conv6_step_mv_out     <= `RVS_STEP_FINE_MV;
      conv6_decay_out       <= RST_N[`RVS_DECAY_BIT];
      linreg2_code_out      <= RST_L2[`RVS_NORMAL_MSB:`RVS_NORMAL_LSB];
      linreg3_code_out      <= RST_L3[`RVS_NORMAL_MSB:`RVS_NORMAL_LSB];
    end else begin
      conv6_target_code_out <= conv6_code_d;
      conv6_step_mv_out     <= step_d;
      conv6_decay_out       <= conv6_normal_q[`RVS_DECAY_BIT];
      linreg2_code_out      <= linreg2_d;
      linreg3_code_out      <= linreg3_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_conv6_sleep_follow;
    @(posedge core_clk_in) disable iff (rst_in)
      sleep_in |=> (conv6_target_code_out == $past(conv6_sleep_q[7:1]));
  endproperty
  a_conv6_sleep_follow: assert property (p_conv6_sleep_follow) else $error("conv6 sleep code not applied"); // R1

  property p_step_size;
    @(posedge core_clk_in) disable iff (rst_in)
      conv6_range_25mv_in |=> (conv6_step_mv_out == 5'h19);
  endproperty
  a_step_size: assert property (p_step_size) else $error("conv6 coarse step not selected"); // R2

  property p_linreg2_sleep;
    @(posedge core_clk_in) disable iff (rst_in)
      sleep_in |=> (linreg2_code_out == $past(linreg2_pair_q[7:4]));
  endproperty
  a_linreg2_sleep: assert property (p_linreg2_sleep) else $error("linreg2 sleep code wrong"); // R3

  property p_linreg2_normal;
    @(posedge core_clk_in) disable iff (rst_in)
      !sleep_in |=> (linreg2_code_out == $past(linreg2_pair_q[3:0]));
  endproperty
  a_linreg2_normal: assert property (p_linreg2_normal) else $error("linreg2 normal code wrong"); // R4

  property p_linreg3_sleep;
    @(posedge core_clk_in) disable iff (rst_in)
      sleep_in |=> (linreg3_code_out == $past(linreg3_pair_q[7:4]));
  endproperty
  a_linreg3_sleep: assert property (p_linreg3_sleep) else $error("linreg3 sleep code wrong"); // R5

  property p_linreg3_normal;
    @(posedge core_clk_in) disable iff (rst_in)
      (reg_wr_in && hit_l3 && !sleep_in) ##1 (!sleep_in && !reg_wr_in)
        |=> (linreg3_code_out == $past(reg_wdata_in[3:0], 2));
  endproperty
  a_linreg3_normal: assert property (p_linreg3_normal) else $error("linreg3 normal code wrong"); // R6

  property p_conv6_mode_switch;
    @(posedge core_clk_in) disable iff (rst_in)
      $fell(sleep_in) |=> (conv6_target_code_out == $past(conv6_normal_q[7:1]));
  endproperty
  a_conv6_mode_switch: assert property (p_conv6_mode_switch) else $error("conv6 normal code not restored"); // R7

  property p_sleep_bit0_zero;
    @(posedge core_clk_in) disable iff (rst_in)
      (reg_rd_in && hit_s) |=> (reg_rvalid_out && !reg_rdata_out[0]);
  endproperty
  a_sleep_bit0_zero: assert property (p_sleep_bit0_zero) else $error("sleep register bit 0 not zero"); // R8

  property p_read_back;
    @(posedge core_clk_in) disable iff (rst_in)
      (reg_wr_in && hit_l2) ##1 (!reg_wr_in && !reg_rd_in) ##1 (reg_rd_in && hit_l2 && !reg_wr_in)
        |=> (reg_rdata_out == $past(reg_wdata_in, 3));
  endproperty
  a_read_back: assert property (p_read_back) else $error("linreg2 read back mismatch"); // R4

  // Host sees valid exactly one edge after its strobe, never held over
  property p_rvalid_pulse;
    @(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> (reg_rvalid_out == $past(reg_rd_in));
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid not one edge after strobe"); // R8

  property p_unmapped_zero;
    @(posedge core_clk_in) disable iff (rst_in)
      (reg_rd_in && !mapped) |=> (reg_rdata_out == `RVS_UNMAPPED_DATA);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // R8

  // Bit 0 must never store a written one, or a later read would expose it
  property p_sleep_wmask;
    @(posedge core_clk_in) disable iff (rst_in)
      (reg_wr_in && hit_s) |=> (conv6_sleep_q == ($past(reg_wdata_in) & `RVS_SLEEP_WMASK));
  endproperty
  a_sleep_wmask: assert property (p_sleep_wmask) else $error("sleep register write not masked"); // R8

  property p_step_fine;
    @(posedge core_clk_in) disable iff (rst_in)
      !conv6_range_25mv_in |=> (conv6_step_mv_out == `RVS_STEP_FINE_MV);
  endproperty
  a_step_fine: assert property (p_step_fine) else $error("conv6 fine step not selected"); // R2

  property p_decay_follow;
    @(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> (conv6_decay_out == $past(conv6_normal_q[`RVS_DECAY_BIT]));
  endproperty
  a_decay_follow: assert property (p_decay_follow) else $error("conv6 decay bit not applied"); // R7

  c_sleep_entry: cover property (@(posedge core_clk_in) disable iff (rst_in) $rose(sleep_in));
  c_sleep_write: cover property (@(posedge core_clk_in) disable iff (rst_in) reg_wr_in && hit_s);
  c_unmapped_rd: cover property (@(posedge core_clk_in) disable iff (rst_in) reg_rd_in && !mapped);
  c_coarse_sleep: cover property (@(posedge core_clk_in) disable iff (rst_in) sleep_in && conv6_range_25mv_in);

endmodule : rvs_regs

//--- logic/rvs_params.svh
// Purpose: Offsets, field positions and factory defaults of the rail voltage registers
// Assumes: 8-bit register space reached through the management-bus register port
// Notes:   Defaults are listed per factory variant, index 0 to 3
`ifndef RVS_PARAMS_SVH
`define RVS_PARAMS_SVH

`define RVS_OFS_CONV6_NORMAL   8'h98
`define RVS_OFS_CONV6_SLEEP    8'h99
`define RVS_OFS_LINREG2_PAIR   8'h9a
`define RVS_OFS_LINREG3_PAIR   8'h9b

`define RVS_CODE7_MSB          7
`define RVS_CODE7_LSB          1
`define RVS_DECAY_BIT          0
`define RVS_SLEEP_MSB          7
`define RVS_SLEEP_LSB          4
`define RVS_NORMAL_MSB         3
`define RVS_NORMAL_LSB         0
`define RVS_SLEEP_WMASK        8'hfe
`define RVS_UNMAPPED_DATA      8'h00

`define RVS_STEP_FINE_MV       5'h0a
`define RVS_STEP_COARSE_MV     5'h19

`define RVS_DEF_CONV6_NORMAL   32'h5870_dcbe
`define RVS_DEF_CONV6_SLEEP    32'h4c70_8cbe
`define RVS_DEF_LINREG2_PAIR   32'h00aa_aaff
`define RVS_DEF_LINREG3_PAIR   32'h00aa_aaaa

`endif

//--- logic/rvs_pkg.sv
// Purpose: Types shared by the rail voltage register bank
// Assumes: Constants live in rvs_params.svh
// Notes:   No numbers here beyond the type encodings
package rvs_pkg;

  typedef enum logic [1:0] {
    RVS_SEL_CONV6_NORMAL  = 2'b00,
    RVS_SEL_CONV6_SLEEP   = 2'b01,
    RVS_SEL_LINREG2_PAIR  = 2'b10,
    RVS_SEL_LINREG3_PAIR  = 2'b11
  } rvs_sel_t;

  typedef logic [7:0] rvs_byte_t;

endpackage : rvs_pkg

//--- tb/rvs_host_model.sv
// Purpose: Management bus host model driving the register port
// Assumes: Strobes change at the falling edge, one byte per access
// Notes:   Idle address and data show the inverted last value, so stale bytes cannot pass
`timescale 1ns/10ps
module rvs_host_model (
  // Clock
  input  wire logic       core_clk_in,
  // Register port
  output logic      [7:0] reg_addr_out  = 8'h00,
  output logic      [7:0] reg_wdata_out = 8'h00,
  output logic            reg_wr_out    = 1'b0,
  output logic            reg_rd_out    = 1'b0,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in
);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(negedge core_clk_in);
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : wr_reg
  // Answer is registered on the taking edge, so sample at the next fall
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic [7:0] v);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(negedge core_clk_in);
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
    d            = reg_rdata_in;
    v            = {7'h00, reg_rvalid_in};
  endtask : rd_reg
endmodule : rvs_host_model

//--- tb/tb.sv
// Purpose: Self-checking bench for the rail voltage register bank
// Assumes: Factory variant 0
// Notes:   Rail outputs checked two falls after any change
`timescale 1ns/10ps
`include "rvs_params.svh"
module tb;
  localparam logic [7:0] DEF_N = 8'(`RVS_DEF_CONV6_NORMAL);
  localparam logic [7:0] DEF_S = 8'(`RVS_DEF_CONV6_SLEEP) & `RVS_SLEEP_WMASK;
  localparam logic [7:0] DEF_2 = 8'(`RVS_DEF_LINREG2_PAIR);
  localparam logic [7:0] DEF_3 = 8'(`RVS_DEF_LINREG3_PAIR);
  logic       core_clk_in = 1'b0;
  logic       rst_in      = 1'b1;
  logic       sleep       = 1'b0;
  logic       rng         = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, rvalid, decay;
  logic [6:0] tgt;
  logic [4:0] step;
  logic [3:0] l2, l3;
  int         miscompares = 0;
  int         total_checks = 0;
  int         cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  rvs_regs #(.VARIANT(0)) rvs_regs_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .sleep_in(sleep), .conv6_range_25mv_in(rng), .conv6_target_code_out(tgt), .conv6_step_mv_out(step),
    .conv6_decay_out(decay), .linreg2_code_out(l2), .linreg3_code_out(l3));
  rvs_host_model rvs_host_model_i (.core_clk_in(core_clk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  // Ceiling well above the roughly fifty cycles the sequence needs
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d, v;
    rvs_host_model_i.rd_reg(a, d, v);
    chk("rvalid", 8'h01, v);
    chk("rdata", exp, d);
  endtask : rd_chk
  task automatic rail_chk(input logic [6:0] t, input logic [3:0] c2, input logic [3:0] c3, input logic [4:0] s);
    repeat (2) @(negedge core_clk_in);
    chk("conv6 target", {1'b0, t}, {1'b0, tgt});
    chk("linreg2 code", {4'h0, c2}, {4'h0, l2});
    chk("linreg3 code", {4'h0, c3}, {4'h0, l3});
    chk("conv6 step", {3'h0, s}, {3'h0, step});
  endtask : rail_chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    rd_chk(8'h98, DEF_N);
    rd_chk(8'h99, DEF_S);
    rd_chk(8'h9a, DEF_2);
    rd_chk(8'h9b, DEF_3);
    rail_chk(DEF_N[7:1], DEF_2[3:0], DEF_3[3:0], 5'h0a);
    rvs_host_model_i.wr_reg(8'h99, 8'hff);
    rd_chk(8'h99, 8'hfe);
    rvs_host_model_i.wr_reg(8'h98, 8'h35);
    rd_chk(8'h98, 8'h35);
    chk("decay", 8'h01, {7'h00, decay});
    rvs_host_model_i.wr_reg(8'h9a, 8'h5c);
    rd_chk(8'h9a, 8'h5c);
    rvs_host_model_i.wr_reg(8'h9b, 8'h3e);
    rail_chk(7'h1a, 4'hc, 4'he, 5'h0a);
    sleep = 1'b1;
    rail_chk(7'h7f, 4'h5, 4'h3, 5'h0a);
    rng = 1'b1;
    rail_chk(7'h7f, 4'h5, 4'h3, 5'h19);
    sleep = 1'b0;
    rail_chk(7'h1a, 4'hc, 4'he, 5'h19);
    rvs_host_model_i.wr_reg(8'h97, 8'h00);
    rd_chk(8'h98, 8'h35);
    rd_chk(8'h9c, 8'h00);
    rst_in = 1'b1;
    @(negedge core_clk_in);
    rst_in = 1'b0;
    rd_chk(8'h9a, DEF_2);
    rd_chk(8'h99, DEF_S);
    rail_chk(DEF_N[7:1], DEF_2[3:0], DEF_3[3:0], 5'h19);
    chk("decay", {7'h00, DEF_N[0]}, {7'h00, decay});
    summarize();
  end
endmodule : tb
